// ==== core/pio_pkg.sv ====
package pio_pkg;
	// port count and pins per port
	localparam int NUM_PORTS = 7;
	localparam int PORT_WIDTH = 8;
	localparam int TOTAL_PINS = 37;
	// implemented pins per port, packed 4 bits each, port 0 in low nibble
	localparam logic [27:0] PORT_PINS = 28'h3_6_8_2_8_8_2;
	// reset values of the per-pin settings
	localparam logic RST_DIR = 1'b0;
	localparam logic RST_DATA = 1'b0;
	localparam logic RST_PULLUP = 1'b0;
	localparam logic RST_SLEW = 1'b1;
	localparam logic RST_DRIVE = 1'b0;
	localparam logic ANALOG_READ_VAL = 1'b0;
	// per-port write select
	typedef logic [NUM_PORTS-1:0] pio_sel_type;
endpackage : pio_pkg

// ==== core/pio_pin.sv ====
`timescale 1ns/100ps
module pio_pin
	import pio_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register writes
	input wire logic data_wr,
	input wire logic dir_wr,
	input wire logic pullup_wr,
	input wire logic slew_wr,
	input wire logic drive_wr,
	input wire logic wr_value,
	// ownership and pin
	input wire logic periph_en,
	input wire logic periph_oe,
	input wire logic periph_out,
	input wire logic analog_en,
	input wire logic pin_in,
	// results
	output logic read_bit,
	output logic dir_q,
	output logic data_q,
	output logic pullup_q,
	output logic slew_q,
	output logic drive_q,
	output logic pin_out,
	output logic pin_oe,
	output logic pullup_on,
	output logic slew_on,
	output logic drive_high
);
	logic dir_ff, data_ff, pullup_ff, slew_ff, drive_ff;
	logic is_output;

	// direction bit
	always_ff @(posedge ref_clk) begin
		if (reset) dir_ff <= RST_DIR;
		else if (dir_wr) dir_ff <= wr_value;
	end

	// data latch, written whatever the direction
	always_ff @(posedge ref_clk) begin
		if (reset) data_ff <= RST_DATA;
		else if (data_wr) data_ff <= wr_value;
	end

	// pin control bits, independent of data and direction
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pullup_ff <= RST_PULLUP;
			slew_ff <= RST_SLEW;
			drive_ff <= RST_DRIVE;
		end else begin
			if (pullup_wr) pullup_ff <= wr_value;
			if (slew_wr) slew_ff <= wr_value;
			if (drive_wr) drive_ff <= wr_value;
		end
	end

	// pin ownership: analog over peripheral over parallel io
	always_comb begin
		if (analog_en) begin
			pin_oe = 1'b0;
			pin_out = 1'b0;
		end else if (periph_en) begin
			pin_oe = periph_oe;
			pin_out = periph_out;
		end else begin
			pin_oe = dir_ff;
			pin_out = data_ff;
		end
	end

	assign is_output = pin_oe;
	// pullup off for outputs and analog pins
	assign pullup_on = pullup_ff && !is_output && !analog_en;
	// slew only matters on a driven pin
	assign slew_on = slew_ff && is_output;
	assign drive_high = drive_ff && is_output;

	// read value selected by direction bit even under peripheral control
	always_comb begin
		if (analog_en) read_bit = ANALOG_READ_VAL;
		else if (dir_ff) read_bit = data_ff;
		else read_bit = pin_in;
	end

	assign dir_q = dir_ff;
	assign data_q = data_ff;
	assign pullup_q = pullup_ff;
	assign slew_q = slew_ff;
	assign drive_q = drive_ff;

	chk_analog_read_zero: assert property (@(posedge ref_clk) disable iff (reset)
		analog_en |-> (read_bit == 1'b0 && !pin_oe && !pullup_on)) else $error("analog pin not isolated");
	chk_pullup_output_off: assert property (@(posedge ref_clk) disable iff (reset)
		pin_oe |-> !pullup_on) else $error("pullup on while output");
	chk_data_write_held: assert property (@(posedge ref_clk) disable iff (reset)
		data_wr |=> data_ff == $past(wr_value)) else $error("data write lost");
	chk_output_read_latch: assert property (@(posedge ref_clk) disable iff (reset)
		(dir_ff && !analog_en) |-> read_bit == data_ff) else $error("output read not latch");
	chk_input_read_pin: assert property (@(posedge ref_clk) disable iff (reset)
		(!dir_ff && !analog_en) |-> read_bit == pin_in) else $error("input read not pin");
	chk_periph_priority: assert property (@(posedge ref_clk) disable iff (reset)
		(periph_en && !analog_en) |-> (pin_oe == periph_oe && pin_out == periph_out)) else $error("peripheral lost pin");
	chk_reset_defaults: assert property (@(posedge ref_clk)
		reset |=> (!dir_ff && !data_ff && !pullup_ff && slew_ff && !drive_ff)) else $error("bad reset defaults");
	chk_slew_input_none: assert property (@(posedge ref_clk) disable iff (reset)
		!pin_oe |-> !slew_on && !drive_high) else $error("slew on input");
endmodule : pio_pin

// ==== core/pio_port_top.sv ====
`timescale 1ns/100ps
// Functional notes
// - Seven ports, 37 pins total, each pin with its own direction bit.
// - An enabled shared peripheral overrides the pin's parallel io function.
// - Reset clears every direction bit to input; peripheral enables are inputs it leaves alone.
// - Reset sets slew on, low drive, pullup off.
// - Direction 0: input, driver off, data read returns pin level.
// - Direction 1: driver on, data read returns last written value.
// - Direction bit selects read source even under peripheral control.
// - Analog function disables digital logic; data bit reads 0.
// - Analog function wins over alternate digital function.
// - Pullup, slew, drive settings independent of data and direction.
// - Pullup enable bit turns on the internal pullup.
// - Pullup forced off when pin is an output, any owner.
// - Pullup forced off under analog control.
// - Slew bit limits output edge rate; no effect on inputs.
// - Drive bit 1 selects high drive, 0 low drive.
// - Data writes latch every bit; only outputs drive it.
// - Reset clears data to zero, not driven.
module pio_port_top
	import pio_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register write port, one strobe per register, port select
	input wire logic [NUM_PORTS-1:0] port_sel,
	input wire logic data_wr,
	input wire logic dir_wr,
	input wire logic pullup_wr,
	input wire logic slew_wr,
	input wire logic drive_wr,
	input wire logic [PORT_WIDTH-1:0] wr_data,
	// register read port
	input wire logic [2:0] rd_port,
	output logic [PORT_WIDTH-1:0] port_data_reg,
	output logic [PORT_WIDTH-1:0] pin_direction_bit,
	output logic [PORT_WIDTH-1:0] pullup_enable_bit,
	output logic [PORT_WIDTH-1:0] slew_control_bit,
	output logic [PORT_WIDTH-1:0] drive_strength_bit,
	// shared functions, flattened port*8+bit
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] periph_en,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] periph_oe,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] periph_out,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] analog_en,
	// pads
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_out,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_oe,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pullup_on,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] slew_on,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] drive_high
);
	localparam int NP = NUM_PORTS * PORT_WIDTH;
	logic [NP-1:0] rd_bit, dir_v, data_v, pu_v, sl_v, dr_v;
	logic [NP-1:0] po, poe, puo, slo, dro;
	logic [PORT_WIDTH-1:0] nxt_rd_data, nxt_rd_dir, nxt_rd_pu, nxt_rd_sl, nxt_rd_dr;

	// pins implemented in a port
	function automatic int pins_of(input int p);
		pins_of = int'(PORT_PINS[p*4 +: 4]);
	endfunction : pins_of

	// pin replication, unimplemented bits tied off
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		for (genvar b = 0; b < PORT_WIDTH; b++) begin : g_bit
			if (b < pins_of(p)) begin : g_pin
				pio_pin u_pin (
					.ref_clk(ref_clk),
					.reset(reset),
					.data_wr(data_wr && port_sel[p]),
					.dir_wr(dir_wr && port_sel[p]),
					.pullup_wr(pullup_wr && port_sel[p]),
					.slew_wr(slew_wr && port_sel[p]),
					.drive_wr(drive_wr && port_sel[p]),
					.wr_value(wr_data[b]),
					.periph_en(periph_en[p*PORT_WIDTH+b]),
					.periph_oe(periph_oe[p*PORT_WIDTH+b]),
					.periph_out(periph_out[p*PORT_WIDTH+b]),
					.analog_en(analog_en[p*PORT_WIDTH+b]),
					.pin_in(pin_in[p*PORT_WIDTH+b]),
					.read_bit(rd_bit[p*PORT_WIDTH+b]),
					.dir_q(dir_v[p*PORT_WIDTH+b]),
					.data_q(data_v[p*PORT_WIDTH+b]),
					.pullup_q(pu_v[p*PORT_WIDTH+b]),
					.slew_q(sl_v[p*PORT_WIDTH+b]),
					.drive_q(dr_v[p*PORT_WIDTH+b]),
					.pin_out(po[p*PORT_WIDTH+b]),
					.pin_oe(poe[p*PORT_WIDTH+b]),
					.pullup_on(puo[p*PORT_WIDTH+b]),
					.slew_on(slo[p*PORT_WIDTH+b]),
					.drive_high(dro[p*PORT_WIDTH+b])
				);
			end else begin : g_none
				assign rd_bit[p*PORT_WIDTH+b] = 1'b0;
				assign dir_v[p*PORT_WIDTH+b] = 1'b0;
				assign data_v[p*PORT_WIDTH+b] = 1'b0;
				assign pu_v[p*PORT_WIDTH+b] = 1'b0;
				assign sl_v[p*PORT_WIDTH+b] = 1'b0;
				assign dr_v[p*PORT_WIDTH+b] = 1'b0;
				assign po[p*PORT_WIDTH+b] = 1'b0;
				assign poe[p*PORT_WIDTH+b] = 1'b0;
				assign puo[p*PORT_WIDTH+b] = 1'b0;
				assign slo[p*PORT_WIDTH+b] = 1'b0;
				assign dro[p*PORT_WIDTH+b] = 1'b0;
			end
		end
	end

	// pad outputs
	assign pin_out = po;
	assign pin_oe = poe;
	assign pullup_on = puo;
	assign slew_on = slo;
	assign drive_high = dro;

	// read mux by port number, out-of-range port reads zero
	always_comb begin
		nxt_rd_data = '0;
		nxt_rd_dir = '0;
		nxt_rd_pu = '0;
		nxt_rd_sl = '0;
		nxt_rd_dr = '0;
		if (int'(rd_port) < NUM_PORTS) begin
			nxt_rd_data = rd_bit[rd_port*PORT_WIDTH +: PORT_WIDTH];
			nxt_rd_dir = dir_v[rd_port*PORT_WIDTH +: PORT_WIDTH];
			nxt_rd_pu = pu_v[rd_port*PORT_WIDTH +: PORT_WIDTH];
			nxt_rd_sl = sl_v[rd_port*PORT_WIDTH +: PORT_WIDTH];
			nxt_rd_dr = dr_v[rd_port*PORT_WIDTH +: PORT_WIDTH];
		end
	end

	// registered read data, one cycle after rd_port
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			port_data_reg <= '0;
			pin_direction_bit <= '0;
			pullup_enable_bit <= '0;
			slew_control_bit <= '0;
			drive_strength_bit <= '0;
		end else begin
			port_data_reg <= nxt_rd_data;
			pin_direction_bit <= nxt_rd_dir;
			pullup_enable_bit <= nxt_rd_pu;
			slew_control_bit <= nxt_rd_sl;
			drive_strength_bit <= nxt_rd_dr;
		end
	end

	chk_pin_total: assert property (@(posedge ref_clk)
		(pins_of(0)+pins_of(1)+pins_of(2)+pins_of(3)+pins_of(4)+pins_of(5)+pins_of(6)) == TOTAL_PINS)
		else $error("pin total wrong");
	chk_read_pipe: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1 |=> port_data_reg == $past(nxt_rd_data)) else $error("read data stale");

	// analog pins never drive and never pull up
	chk_analog_pad_off: assert property (@(posedge ref_clk) disable iff (reset)
		((pin_oe | pullup_on) & analog_en) == '0) else $error("analog pad not isolated");

	// unimplemented pins stay quiet whatever is written
	chk_unused_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		(pin_oe & ~g_wr_chk_mask()) == '0) else $error("unused pin driven");

	// mask of implemented pins across all ports
	function automatic logic [NP-1:0] g_wr_chk_mask();
		g_wr_chk_mask = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			for (int b = 0; b < PORT_WIDTH; b++) begin
				if (b < pins_of(p)) g_wr_chk_mask[p*PORT_WIDTH+b] = 1'b1;
			end
		end
	endfunction : g_wr_chk_mask

	// per-port write landing, one cycle after the strobe
	for (genvar q = 0; q < NUM_PORTS; q++) begin : g_wr_chk
		localparam logic [PORT_WIDTH-1:0] IMPL_MASK = PORT_WIDTH'((1 << pins_of(q)) - 1);
		// a direction write aimed at this port
		sequence s_dir_write;
			dir_wr && port_sel[q];
		endsequence
		// a pullup write aimed at this port
		sequence s_pullup_write;
			pullup_wr && port_sel[q];
		endsequence
		// a data write aimed at this port
		sequence s_data_write;
			data_wr && port_sel[q];
		endsequence
		chk_dir_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
			s_dir_write |=> dir_v[q*PORT_WIDTH +: PORT_WIDTH] == ($past(wr_data) & IMPL_MASK))
			else $error("direction write lost");
		chk_pullup_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
			s_pullup_write |=> pu_v[q*PORT_WIDTH +: PORT_WIDTH] == ($past(wr_data) & IMPL_MASK))
			else $error("pullup write lost");
		chk_data_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
			s_data_write |=> data_v[q*PORT_WIDTH +: PORT_WIDTH] == ($past(wr_data) & IMPL_MASK))
			else $error("data write lost on port");
	end
endmodule : pio_port_top

// ==== tb/pio_board_model.sv ====
`timescale 1ns/100ps
module pio_board_model
	import pio_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// device pad side
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_out,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_oe,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pullup_on,
	// board drive
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] ext_en,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] ext_val,
	// resolved pad level
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in
);
	logic float_ff = 1'b0;
	// floating pads wander each cycle, never a stable guess
	always @(posedge ref_clk) begin
		float_ff <= ~float_ff;
	end
	// pad level: device driver, board driver, pullup, else floating
	always_comb begin
		for (int i = 0; i < NUM_PORTS*PORT_WIDTH; i++) begin
			if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (ext_en[i]) pin_in[i] = ext_val[i];
			else if (pullup_on[i]) pin_in[i] = 1'b1;
			else pin_in[i] = float_ff ^ i[0];
		end
	end
endmodule : pio_board_model

// ==== tb/parallel_io_pin_control_tb.sv ====
`timescale 1ns/100ps
module parallel_io_pin_control_tb
	import pio_pkg::*;
;
	typedef struct packed {logic [7:0] dir, dat, pu, pe, po, an, ext, rd, oe, out, puo;} pio_row_type;
	localparam int W = NUM_PORTS*PORT_WIDTH;
	logic ref_clk = 1'b0, reset = 1'b1, data_wr = 1'b0, dir_wr = 1'b0, pullup_wr = 1'b0, slew_wr = 1'b0;
	logic drive_wr = 1'b0;
	logic [6:0] port_sel = '0;
	logic [7:0] wr_data = '0, port_data_reg, pin_direction_bit, pullup_enable_bit, slew_control_bit;
	logic [7:0] drive_strength_bit;
	logic [2:0] rd_port = '0;
	logic [W-1:0] periph_en = '0, periph_oe = '0, periph_out = {7{8'h33}}, analog_en = '0, ext_en = '1;
	logic [W-1:0] ext_val = '0, pin_in, pin_out, pin_oe, pullup_on, slew_on, drive_high;
	int n_errors = 0, num_checks = 0;
	// port 1 cases: settings, shared functions, board level, expected pads
	pio_row_type rows [6] = '{
		'{8'h00, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h3c, 8'h00, 8'h00, 8'h00},
		'{8'hff, 8'ha5, 8'hff, 8'h00, 8'h00, 8'h00, 8'h3c, 8'ha5, 8'hff, 8'ha5, 8'h00},
		'{8'h0f, 8'ha5, 8'hff, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h35, 8'h0f, 8'h05, 8'hf0},
		'{8'hf0, 8'ha5, 8'hff, 8'hff, 8'h0f, 8'h00, 8'h3c, 8'ha3, 8'h0f, 8'h03, 8'hf0},
		'{8'hff, 8'ha5, 8'hff, 8'hff, 8'hf0, 8'h0f, 8'h3c, 8'ha0, 8'hf0, 8'h30, 8'h00},
		'{8'h00, 8'h5a, 8'hff, 8'h00, 8'h00, 8'h00, 8'hc3, 8'hc3, 8'h00, 8'h00, 8'hff}};
	// clock
	always begin
		#4 ref_clk = ~ref_clk;
	end
	pio_port_top pio_port_top_inst (.ref_clk(ref_clk), .reset(reset), .port_sel(port_sel), .data_wr(data_wr),
		.dir_wr(dir_wr), .pullup_wr(pullup_wr), .slew_wr(slew_wr), .drive_wr(drive_wr), .wr_data(wr_data),
		.rd_port(rd_port), .port_data_reg(port_data_reg), .pin_direction_bit(pin_direction_bit),
		.pullup_enable_bit(pullup_enable_bit), .slew_control_bit(slew_control_bit),
		.drive_strength_bit(drive_strength_bit), .periph_en(periph_en), .periph_oe(periph_oe),
		.periph_out(periph_out), .analog_en(analog_en), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_on(pullup_on), .slew_on(slew_on), .drive_high(drive_high));
	pio_board_model pio_board_model_inst (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
	// compare and count
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	// one-cycle write, strobes {data, dir, pullup, slew, drive}
	task automatic wr(input logic [6:0] s, input logic [4:0] st, input logic [7:0] d);
		@(posedge ref_clk);
		port_sel <= s;
		{data_wr, dir_wr, pullup_wr, slew_wr, drive_wr} <= st;
		wr_data <= d;
		@(posedge ref_clk);
		{data_wr, dir_wr, pullup_wr, slew_wr, drive_wr} <= 5'b00000;
	endtask : wr
	// registered read, settled after the answering edge
	task automatic rd(input logic [2:0] p);
		@(posedge ref_clk);
		rd_port <= p;
		@(posedge ref_clk);
		#1;
	endtask : rd
	// verdict
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		#(8*3000);
		n_errors++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		rd(3'd1);
		chk("dir", pin_direction_bit, 8'h00);
		chk("slew", slew_control_bit, 8'hff);
		chk("drive", drive_strength_bit, 8'h00);
		chk("pullup", pullup_enable_bit, 8'h00);
		chk("oe_any", {7'h00, |pin_oe}, 8'h00);
		wr(7'h02, 5'b00001, 8'hf0);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			periph_en[15:8] <= rows[i].pe;
			periph_oe[15:8] <= rows[i].po;
			analog_en[15:8] <= rows[i].an;
			ext_val[15:8] <= rows[i].ext;
			wr(7'h02, 5'b10000, rows[i].dat);
			wr(7'h02, 5'b01000, rows[i].dir);
			wr(7'h02, 5'b00100, rows[i].pu);
			rd(3'd1);
			chk("read", port_data_reg, rows[i].rd);
			chk("dir", pin_direction_bit, rows[i].dir);
			chk("pu_bits", pullup_enable_bit, rows[i].pu);
			chk("drv_bits", drive_strength_bit, 8'hf0);
			chk("oe", pin_oe[15:8], rows[i].oe);
			chk("out", pin_out[15:8] & pin_oe[15:8], rows[i].out);
			chk("pull", pullup_on[15:8], rows[i].puo);
			chk("slew_on", slew_on[15:8], rows[i].oe);
			chk("drive_hi", drive_high[15:8], rows[i].oe & 8'hf0);
		end
		// data latched while input now drives
		wr(7'h02, 5'b01000, 8'hff);
		rd(3'd1);
		chk("latched", pin_out[15:8], 8'h5a);
		// pin settings leave data and direction alone
		wr(7'h02, 5'b00111, 8'h00);
		rd(3'd1);
		chk("dir", pin_direction_bit, 8'hff);
		chk("read", port_data_reg, 8'h5a);
		chk("slew", slew_control_bit, 8'h00);
		// unconnected inputs held by pullups
		@(posedge ref_clk);
		ext_en <= '0;
		wr(7'h02, 5'b01000, 8'h00);
		wr(7'h02, 5'b00100, 8'hff);
		rd(3'd1);
		chk("pulled", port_data_reg, 8'hff);
		// implemented pin counts
		wr(7'h7f, 5'b01000, 8'hff);
		rd(3'd0);
		chk("count", 8'($countones(pin_oe)), 8'd37);
		chk("dir_p0", pin_direction_bit, 8'h03);
		rd(3'd6);
		chk("dir_p6", pin_direction_bit, 8'h07);
		rd(3'd7);
		chk("dir_p7", pin_direction_bit, 8'h00);
		// second reset mid-run
		@(posedge ref_clk);
		reset <= 1'b1;
		@(posedge ref_clk);
		reset <= 1'b0;
		#1;
		chk("oe_any", {7'h00, |pin_oe}, 8'h00);
		chk("pull_any", {7'h00, |pullup_on}, 8'h00);
		wr(7'h02, 5'b01000, 8'hff);
		rd(3'd1);
		chk("slew", slew_control_bit, 8'hff);
		chk("zero_data", pin_out[15:8], 8'h00);
		end_of_test();
	end
endmodule : parallel_io_pin_control_tb
